/* logic/cosi_top.sv */
// Status indicator top: run and error lamps, address alarm, APB registers.
// Assumes protocol engine inputs on pclk and settings held stable by the host.
`timescale 1ns/1ps
`default_nettype none
`include "cosi_map.svh"

// How it works
// (R1) Run lamp: on when operational, blinking pre-operational, single flash stopped.
// (R2) Error lamp on at bus-off, blinking on init failure, off when healthy.
// (R3) Error lamp single-flashes on a fault or excessive error frames.
// (R4) Error lamp double-flashes after a guarding or heartbeat event.
// (R5) Bit-rate detection flickers both lamps alternately, firmware version 3102 onward.
// (R6) Patterns and rates follow the published indicator timing.
// (R7) Node address zero at power-up raises an alarm and blocks joining.
// (R8) Address and bit-rate settings are taken only once after reset.
// (R9) Error lamp priority bus-off, init, supervision, frames; timing is programmable.
module cosi_top
    import cosi_pkg::*;
#(
    parameter int TICK_DEFAULT = 1000000,
    parameter logic [15:0] FW_VERSION = `COSI_FLICKER_MIN_VER,
    parameter int ADDR_W = 7,
    parameter int RATE_W = 4
)
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`COSI_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Protocol engine state
    input wire logic [1:0] nmt_state,
    input wire logic bus_off,
    input wire logic init_fail,
    input wire logic fault,
    input wire logic error_frames_excess,
    input wire logic guard_event,
    input wire logic autobaud_active,
    // Settings
    input wire logic [ADDR_W-1:0] node_address_setting,
    input wire logic [RATE_W-1:0] bit_rate_setting,
    output logic [ADDR_W-1:0] node_address_active,
    output logic [RATE_W-1:0] bit_rate_active,
    output logic join_enable,
    output logic address_zero_alarm,
    // Lamps and interrupt
    output logic run_lamp,
    output logic err_lamp,
    output logic irq
);

    localparam logic [`COSI_TICK_W-1:0] TICK_RESET = `COSI_TICK_W'(TICK_DEFAULT);
    localparam logic FLICKER_OK = (FW_VERSION >= `COSI_FLICKER_MIN_VER);

    logic [`COSI_CTRL_W-1:0] ctrl_r;
    logic [`COSI_TICK_W-1:0] tick_r;
    logic [`COSI_IRQ_W-1:0] irq_en_r;
    logic [`COSI_IRQ_W-1:0] irq_clr;
    logic [`COSI_IRQ_W-1:0] irq_status;
    logic [`COSI_IRQ_W-1:0] irq_evt;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic pslverr_nxt;
    logic wr_en;
    logic rd_en;
    cosi_cap_t cap_r;
    logic [ADDR_W-1:0] addr_r;
    logic [RATE_W-1:0] rate_r;
    logic alarm_r;
    logic run_r;
    logic err_r;
    logic run_nxt;
    logic err_nxt;
    logic show_abr;
    cosi_pat_t pat;
    cosi_evt_t evt_now;
    cosi_evt_t evt_last_r;

    function automatic logic mapped(input logic [`COSI_ADDR_W-1:0] a);
        mapped = (a == `COSI_OFF_CTRL) || (a == `COSI_OFF_STATUS)
            || (a == `COSI_OFF_IRQ_STATUS) || (a == `COSI_OFF_IRQ_CLEAR)
            || (a == `COSI_OFF_IRQ_ENABLE) || (a == `COSI_OFF_TICK);
    endfunction

    // APB: zero wait states; the access phase completes in its first cycle
    assign pready = 1'b1;
    assign wr_en = ce && psel && penable && pwrite;
    assign rd_en = ce && psel && penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= `COSI_CTRL_RESET;
        else if (wr_en && paddr == `COSI_OFF_CTRL)
            ctrl_r <= pwdata[`COSI_CTRL_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_r <= TICK_RESET;
        else if (wr_en && paddr == `COSI_OFF_TICK)
            tick_r <= pwdata[`COSI_TICK_W-1:0]; // R9
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en_r <= `COSI_IRQ_RESET;
        else if (wr_en && paddr == `COSI_OFF_IRQ_ENABLE)
            irq_en_r <= pwdata[`COSI_IRQ_W-1:0];
    end

    assign irq_clr = (wr_en && paddr == `COSI_OFF_IRQ_CLEAR) ? pwdata[`COSI_IRQ_W-1:0] : '0;

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        pslverr_nxt = !mapped(paddr);
        case (paddr)
            `COSI_OFF_CTRL: rd_nxt[`COSI_CTRL_W-1:0] = ctrl_r;
            `COSI_OFF_STATUS:
            begin
                rd_nxt[`COSI_ST_RUN_LAMP] = run_r;
                rd_nxt[`COSI_ST_ERR_LAMP] = err_r;
                rd_nxt[`COSI_ST_ALARM] = alarm_r;
                rd_nxt[`COSI_ST_JOIN] = join_enable;
                rd_nxt[`COSI_ST_NMT_LO +: 2] = nmt_state;
                rd_nxt[`COSI_ST_ADDR_LO +: ADDR_W] = addr_r;
                rd_nxt[`COSI_ST_RATE_LO +: RATE_W] = rate_r;
            end
            `COSI_OFF_IRQ_STATUS: rd_nxt[`COSI_IRQ_W-1:0] = irq_status;
            `COSI_OFF_IRQ_ENABLE: rd_nxt[`COSI_IRQ_W-1:0] = irq_en_r;
            `COSI_OFF_TICK: rd_nxt[`COSI_TICK_W-1:0] = tick_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data is registered in the setup cycle and valid in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (ce && psel && !penable && !pwrite)
            prdata_r <= rd_nxt;
    end

    assign prdata = prdata_r;
    assign pslverr = psel && penable && pslverr_nxt;

    // Settings are sampled once after reset release; later changes wait
    // for the next power cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_r <= COSI_CAP_WAIT;
        else if (ce)
        begin
            case (cap_r)
                COSI_CAP_WAIT: cap_r <= COSI_CAP_TAKE;
                COSI_CAP_TAKE: cap_r <= COSI_CAP_DONE;
                COSI_CAP_DONE: cap_r <= COSI_CAP_DONE;
                default: cap_r <= COSI_CAP_WAIT;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_r <= '0;
            rate_r <= '0;
        end
        else if (ce && cap_r == COSI_CAP_TAKE)
        begin
            addr_r <= node_address_setting; // R8
            rate_r <= bit_rate_setting; // R8
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_r <= 1'b0;
        else if (ce && cap_r == COSI_CAP_TAKE)
            alarm_r <= (node_address_setting == '0); // R7
    end

    assign node_address_active = addr_r;
    assign bit_rate_active = rate_r;
    assign address_zero_alarm = alarm_r;
    assign join_enable = (cap_r == COSI_CAP_DONE) && !alarm_r; // R7

    cosi_pattern_gen u_pat (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick_cycles(tick_r),
        .pat(pat)
    );

    assign show_abr = autobaud_active && FLICKER_OK && ctrl_r[`COSI_CTRL_ABR_EN]; // R5

    always_comb
    begin
        run_nxt = 1'b0;
        err_nxt = 1'b0;
        if (show_abr)
        begin
            run_nxt = pat.flicker; // R5
            err_nxt = ~pat.flicker; // R5
        end
        else
        begin
            case (nmt_state)
                `COSI_NMT_OPER: run_nxt = 1'b1; // R1
                `COSI_NMT_PREOP: run_nxt = pat.blink; // R1
                `COSI_NMT_STOP: run_nxt = pat.single_flash; // R1
                default: run_nxt = 1'b0;
            endcase
            if (bus_off)
                err_nxt = 1'b1; // R2 R9
            else if (init_fail)
                err_nxt = pat.blink; // R2 R9
            else if (guard_event)
                err_nxt = pat.double_flash; // R4 R9
            else if (fault || error_frames_excess)
                err_nxt = pat.single_flash; // R3 R9
            else
                err_nxt = 1'b0; // R2
        end
        if (!ctrl_r[`COSI_CTRL_LAMP_EN])
        begin
            run_nxt = 1'b0;
            err_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_r <= 1'b0;
            err_r <= 1'b0;
        end
        else if (ce)
        begin
            run_r <= run_nxt;
            err_r <= err_nxt;
        end
    end

    assign run_lamp = run_r;
    assign err_lamp = err_r;

    // Interrupt events are rising edges of the conditions
    always_comb
    begin
        evt_now.bus_off = bus_off;
        evt_now.init_fail = init_fail;
        evt_now.guard_event = guard_event;
        evt_now.fault = fault || error_frames_excess;
        evt_now.addr_alarm = alarm_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_last_r <= '0;
        else if (ce)
            evt_last_r <= evt_now;
    end

    assign irq_evt = evt_now & ~evt_last_r;

    cosi_irq #(.W(`COSI_IRQ_W)) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .evt(irq_evt),
        .clr(irq_clr),
        .enable(irq_en_r),
        .status(irq_status),
        .irq(irq)
    );

    sequence s_cap_take;
        ce && cap_r == COSI_CAP_TAKE;
    endsequence

    property p_oper_on;
        @(posedge pclk) disable iff (!presetn)
        (ce && !show_abr && ctrl_r[`COSI_CTRL_LAMP_EN] && nmt_state == `COSI_NMT_OPER)
            |=> run_lamp;
    endproperty
    a_oper_on: assert property (p_oper_on) else $error("run lamp not on"); // R1

    property p_stop_single;
        @(posedge pclk) disable iff (!presetn)
        (ce && !show_abr && ctrl_r[`COSI_CTRL_LAMP_EN] && nmt_state == `COSI_NMT_STOP)
            |=> (run_lamp == $past(pat.single_flash));
    endproperty
    a_stop_single: assert property (p_stop_single) else $error("stopped pattern wrong"); // R1

    property p_busoff_on;
        @(posedge pclk) disable iff (!presetn)
        (ce && !show_abr && ctrl_r[`COSI_CTRL_LAMP_EN] && bus_off) |=> err_lamp;
    endproperty
    a_busoff_on: assert property (p_busoff_on) else $error("bus-off lamp not on"); // R2

    property p_healthy_off;
        @(posedge pclk) disable iff (!presetn)
        (ce && !show_abr && !bus_off && !init_fail && !guard_event && !fault
            && !error_frames_excess) |=> !err_lamp;
    endproperty
    a_healthy_off: assert property (p_healthy_off) else $error("error lamp lit"); // R2

    property p_frames_single;
        @(posedge pclk) disable iff (!presetn)
        (ce && !show_abr && ctrl_r[`COSI_CTRL_LAMP_EN] && error_frames_excess && !bus_off
            && !init_fail && !guard_event) |=> (err_lamp == $past(pat.single_flash));
    endproperty
    a_frames_single: assert property (p_frames_single) else $error("frame flash wrong"); // R3

    property p_guard_double;
        @(posedge pclk) disable iff (!presetn)
        (ce && !show_abr && ctrl_r[`COSI_CTRL_LAMP_EN] && guard_event && !bus_off
            && !init_fail) |=> (err_lamp == $past(pat.double_flash));
    endproperty
    a_guard_double: assert property (p_guard_double) else $error("guard flash wrong"); // R4

    property p_abr_alt;
        @(posedge pclk) disable iff (!presetn)
        (ce && show_abr && ctrl_r[`COSI_CTRL_LAMP_EN]) |=> (run_lamp != err_lamp);
    endproperty
    a_abr_alt: assert property (p_abr_alt) else $error("lamps not alternating"); // R5

    property p_zero_alarm;
        @(posedge pclk) disable iff (!presetn)
        (s_cap_take and (node_address_setting == '0)) |=> (address_zero_alarm && !join_enable);
    endproperty
    a_zero_alarm: assert property (p_zero_alarm) else $error("zero address not flagged"); // R7

    property p_settings_hold;
        @(posedge pclk) disable iff (!presetn)
        (cap_r == COSI_CAP_DONE) |=> $stable(node_address_active) && $stable(bit_rate_active);
    endproperty
    a_settings_hold: assert property (p_settings_hold) else $error("setting changed live"); // R8

endmodule
`default_nettype wire

/* common/cosi_map.svh */
// Constants for the fieldbus status indicator: register offsets, field
// positions, reset values and flash timing in ticks.
// Assumes APB with 32-bit data, one aligned word per register.
`ifndef COSI_MAP_SVH
`define COSI_MAP_SVH

`define COSI_ADDR_W 8
`define COSI_OFF_CTRL 8'h00
`define COSI_OFF_STATUS 8'h04
`define COSI_OFF_IRQ_STATUS 8'h08
`define COSI_OFF_IRQ_CLEAR 8'h0C
`define COSI_OFF_IRQ_ENABLE 8'h10
`define COSI_OFF_TICK 8'h14

`define COSI_CTRL_LAMP_EN 0
`define COSI_CTRL_ABR_EN 1
`define COSI_CTRL_W 2
`define COSI_CTRL_RESET 2'h3

`define COSI_ST_RUN_LAMP 0
`define COSI_ST_ERR_LAMP 1
`define COSI_ST_ALARM 2
`define COSI_ST_JOIN 3
`define COSI_ST_NMT_LO 4
`define COSI_ST_ADDR_LO 8
`define COSI_ST_RATE_LO 16

`define COSI_IRQ_W 5
`define COSI_IRQ_RESET 5'h00

`define COSI_NMT_INIT 2'h0
`define COSI_NMT_PREOP 2'h1
`define COSI_NMT_OPER 2'h2
`define COSI_NMT_STOP 2'h3

// One tick is half the flicker period (one on or off phase); 50 ms
`define COSI_TICK_MS 50
`define COSI_TICK_W 24
`define COSI_FLASH_ON_TICKS 5'h04
`define COSI_DOUBLE_GAP_END 5'h08
`define COSI_DOUBLE_ON2_END 5'h0C
`define COSI_SINGLE_LAST 5'h17
`define COSI_DOUBLE_LAST 5'h1F
`define COSI_BLINK_BIT 2
`define COSI_FLICKER_MIN_VER 16'h0C1E

`endif

/* common/cosi_pkg.sv */
// Types shared by the status indicator modules.
// Assumes cosi_map.svh supplies the numeric constants.
package cosi_pkg;

    typedef struct packed {
        logic bus_off;
        logic init_fail;
        logic guard_event;
        logic fault;
        logic addr_alarm;
    } cosi_evt_t;

    typedef struct packed {
        logic blink;
        logic single_flash;
        logic double_flash;
        logic flicker;
    } cosi_pat_t;

    typedef enum logic [2:0] {
        COSI_CAP_WAIT = 3'b001,
        COSI_CAP_TAKE = 3'b010,
        COSI_CAP_DONE = 3'b100
    } cosi_cap_t;

endpackage

/* logic/cosi_pattern_gen.sv */
// Flash pattern generator: blink, single flash, double flash and flicker.
// Assumes a tick length in clock cycles from a software register.
`timescale 1ns/1ps
`default_nettype none
`include "cosi_map.svh"

module cosi_pattern_gen
    import cosi_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Timing
    input wire logic [`COSI_TICK_W-1:0] tick_cycles,
    // Patterns
    output cosi_pat_t pat
);

    logic [`COSI_TICK_W-1:0] cyc_r;
    logic [4:0] ph24_r;
    logic [4:0] ph32_r;
    logic tick;

    // A zero tick length behaves as one cycle, so the phases never stall
    assign tick = (cyc_r >= tick_cycles - `COSI_TICK_W'(1)) || (tick_cycles == '0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cyc_r <= '0;
        else if (ce)
            cyc_r <= tick ? '0 : cyc_r + `COSI_TICK_W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph24_r <= 5'h00;
            ph32_r <= 5'h00;
        end
        else if (ce && tick)
        begin
            ph24_r <= (ph24_r == `COSI_SINGLE_LAST) ? 5'h00 : ph24_r + 5'h01;
            ph32_r <= (ph32_r == `COSI_DOUBLE_LAST) ? 5'h00 : ph32_r + 5'h01;
        end
    end

    // 200 ms on / 200 ms off, 200 ms flash then 1 s off, two flashes then 1 s
    always_comb
    begin
        pat.blink = ~ph32_r[`COSI_BLINK_BIT]; // R6
        pat.single_flash = ph24_r < `COSI_FLASH_ON_TICKS; // R6
        pat.double_flash = (ph32_r < `COSI_FLASH_ON_TICKS)
            || ((ph32_r >= `COSI_DOUBLE_GAP_END) && (ph32_r < `COSI_DOUBLE_ON2_END)); // R6
        pat.flicker = ~ph32_r[0]; // R6
    end

    property p_single_len;
        @(posedge pclk) disable iff (!presetn)
        (ce && tick && ph24_r == `COSI_SINGLE_LAST) |=> (ph24_r == 5'h00);
    endproperty
    a_single_len: assert property (p_single_len) else $error("single phase wrap wrong"); // R6

endmodule
`default_nettype wire

/* logic/cosi_irq.sv */
// Sticky event status with enable mask and write-one-to-clear.
// Assumes one-cycle event pulses and a clear pulse from the bus slave.
`timescale 1ns/1ps
`default_nettype none
`include "cosi_map.svh"

module cosi_irq
    import cosi_pkg::*;
#(
    parameter int W = `COSI_IRQ_W
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Events and software control
    input wire logic [W-1:0] evt,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] enable,
    // Results
    output logic [W-1:0] status,
    output logic irq
);

    logic [W-1:0] status_r;

    // An event in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_r <= W'(`COSI_IRQ_RESET);
        else if (ce)
            status_r <= (status_r & ~clr) | evt;
    end

    assign status = status_r;
    assign irq = |(status_r & enable);

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (ce && (evt & clr) != '0) |=> ((status_r & $past(evt & clr)) == $past(evt & clr));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

endmodule
`default_nettype wire

/* testbench/cosi_engine_model.sv */
// Behavioural protocol engine on the bus side of the status indicator.
// It turns a scene number from the bench into engine state levels.
// Assumes the bench changes the scene only between measurements.
`timescale 1ns/1ps
`default_nettype none

module cosi_engine_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Scene select from the bench
    input wire logic [3:0] scene,
    // Engine state toward the indicator
    output logic [1:0] nmt_state,
    output logic bus_off,
    output logic init_fail,
    output logic fault,
    output logic error_frames_excess,
    output logic guard_event,
    output logic autobaud_active
);
    // Levels change just after an edge, like the real engine on the same clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmt_state <= 2'h0;
            bus_off <= 1'b0;
            init_fail <= 1'b0;
            fault <= 1'b0;
            error_frames_excess <= 1'b0;
            guard_event <= 1'b0;
            autobaud_active <= 1'b0;
        end
        else
        begin
            case (scene)
                4'h1: nmt_state <= 2'h2;
                4'h2, 4'hC: nmt_state <= 2'h1;
                4'h3: nmt_state <= 2'h3;
                default: nmt_state <= 2'h0;
            endcase
            bus_off <= (scene == 4'h4) || (scene == 4'h9);
            init_fail <= (scene == 4'h5) || (scene == 4'hA);
            guard_event <= scene inside {4'h6, 4'h9, 4'hA, 4'hB};
            fault <= (scene == 4'h7) || (scene == 4'h9);
            error_frames_excess <= (scene == 4'h8) || (scene == 4'hB);
            autobaud_active <= (scene == 4'hC);
        end
    end
endmodule

`default_nettype wire

/* testbench/cosi_top_test.sv */
// Self-checking bench for the status indicator top.
// Assumes the engine model on the bus side and APB access from this bench.
`timescale 1ns/1ps
`default_nettype none
`include "cosi_map.svh"

module cosi_top_test;
    import cosi_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pslverr, pready, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0] nmt_state;
    logic bus_off, init_fail, fault, error_frames_excess, guard_event, autobaud_active;
    logic [6:0] node_address_setting, node_address_active;
    logic [3:0] bit_rate_setting, bit_rate_active, scene;
    logic join_enable, address_zero_alarm, run_lamp, err_lamp, err_seen;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    // Per scene: run on-cycles, run rises, err on-cycles, err rises over 96 ticks
    int exp_t [13][4] = '{'{0, 0, 0, 0}, '{192, 0, 0, 0}, '{96, 12, 0, 0},
        '{32, 4, 0, 0}, '{0, 0, 192, 0}, '{0, 0, 96, 12}, '{0, 0, 48, 6},
        '{0, 0, 32, 4}, '{0, 0, 32, 4}, '{0, 0, 192, 0}, '{0, 0, 96, 12},
        '{0, 0, 48, 6}, '{96, 48, 96, 48}};

    cosi_top #(.TICK_DEFAULT(3)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nmt_state(nmt_state), .bus_off(bus_off),
        .init_fail(init_fail), .fault(fault), .error_frames_excess(error_frames_excess),
        .guard_event(guard_event), .autobaud_active(autobaud_active),
        .node_address_setting(node_address_setting), .bit_rate_setting(bit_rate_setting),
        .node_address_active(node_address_active), .bit_rate_active(bit_rate_active),
        .join_enable(join_enable), .address_zero_alarm(address_zero_alarm),
        .run_lamp(run_lamp), .err_lamp(err_lamp), .irq(irq));

    cosi_engine_model engine (.pclk(pclk), .presetn(presetn), .scene(scene),
        .nmt_state(nmt_state), .bus_off(bus_off), .init_fail(init_fail), .fault(fault),
        .error_frames_excess(error_frames_excess), .guard_event(guard_event),
        .autobaud_active(autobaud_active));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, only the bench timeout ends a wait
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        chk(nm, rdat, exp);
    endtask

    task automatic settle();
        @(posedge pclk);
        #1;
    endtask

    task automatic power_cycle();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) settle();
    endtask

    // Counts lamp on-cycles and rises over 192 cycles, a whole number of every period
    task automatic scene_chk(input logic [3:0] s, input int k);
        int ron, rrs, eon, ers, same;
        logic pr, pe;
        ron = 0;
        rrs = 0;
        eon = 0;
        ers = 0;
        same = 0;
        @(posedge pclk);
        scene <= s;
        repeat (4) settle();
        pr = run_lamp;
        pe = err_lamp;
        repeat (192)
        begin
            settle();
            ron += int'(run_lamp === 1'b1);
            rrs += int'(run_lamp === 1'b1 && pr === 1'b0);
            eon += int'(err_lamp === 1'b1);
            ers += int'(err_lamp === 1'b1 && pe === 1'b0);
            same += int'(run_lamp === err_lamp && run_lamp === 1'b1);
            pr = run_lamp;
            pe = err_lamp;
        end
        chk("run on", 32'(ron), 32'(exp_t[k][0]));
        chk("run rises", 32'(rrs), 32'(exp_t[k][1]));
        chk("err on", 32'(eon), 32'(exp_t[k][2]));
        chk("err rises", 32'(ers), 32'(exp_t[k][3]));
        chk("both lit", 32'(same), 32'h0000_0000);
    endtask

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        scene = 4'h0;
        node_address_setting = 7'h00;
        bit_rate_setting = 4'hA;
        power_cycle();
        chk("alarm", 32'(address_zero_alarm), 32'h1);
        chk("join", 32'(join_enable), 32'h0);
        rd("irq status", `COSI_OFF_IRQ_STATUS, 32'h0000_0001);
        rd("ctrl", `COSI_OFF_CTRL, 32'h0000_0003);
        rd("irq enable", `COSI_OFF_IRQ_ENABLE, 32'h0000_0000);
        rd("tick", `COSI_OFF_TICK, 32'h0000_0003);
        rd("unmapped", 8'h3C, 32'h0000_0000);
        chk("slverr", 32'(err_seen), 32'h1);
        @(posedge pclk);
        node_address_setting <= 7'h05;
        bit_rate_setting <= 4'h3;
        repeat (10) settle();
        chk("addr held", 32'(node_address_active), 32'h0);
        chk("rate held", 32'(bit_rate_active), 32'hA);
        chk("alarm held", 32'(address_zero_alarm), 32'h1);
        power_cycle();
        chk("alarm off", 32'(address_zero_alarm), 32'h0);
        chk("join on", 32'(join_enable), 32'h1);
        chk("addr new", 32'(node_address_active), 32'h5);
        chk("rate new", 32'(bit_rate_active), 32'h3);
        apb(`COSI_OFF_TICK, 1'b1, 32'h0000_0002);
        rd("tick", `COSI_OFF_TICK, 32'h0000_0002);
        for (int i = 0; i < 13; i++)
            scene_chk(4'(i), i);
        scene_chk(4'h1, 1);
        rd("status", `COSI_OFF_STATUS, 32'h0003_0529);
        // Flicker display off: engine state decides the run lamp alone
        apb(`COSI_OFF_CTRL, 1'b1, 32'h0000_0001);
        scene_chk(4'hC, 2);
        apb(`COSI_OFF_CTRL, 1'b1, 32'h0000_0000);
        scene_chk(4'h9, 0);
        apb(`COSI_OFF_CTRL, 1'b1, 32'h0000_0003);
        scene_chk(4'h0, 0);
        apb(`COSI_OFF_IRQ_CLEAR, 1'b1, 32'h0000_001F);
        rd("irq cleared", `COSI_OFF_IRQ_STATUS, 32'h0000_0000);
        rd("clear reads", `COSI_OFF_IRQ_CLEAR, 32'h0000_0000);
        scene_chk(4'h9, 9);
        rd("irq events", `COSI_OFF_IRQ_STATUS, 32'h0000_0016);
        chk("irq masked", 32'(irq), 32'h0);
        apb(`COSI_OFF_IRQ_ENABLE, 1'b1, 32'h0000_0004);
        settle();
        chk("irq raised", 32'(irq), 32'h1);
        apb(`COSI_OFF_IRQ_CLEAR, 1'b1, 32'h0000_0004);
        rd("irq after clear", `COSI_OFF_IRQ_STATUS, 32'h0000_0012);
        settle();
        chk("irq dropped", 32'(irq), 32'h0);
        // Enable low: the engine turns operational but both lamps must hold
        @(posedge pclk);
        ce <= 1'b0;
        scene <= 4'h1;
        repeat (8) settle();
        chk("ce run held", 32'(run_lamp), 32'h0);
        chk("ce err held", 32'(err_lamp), 32'h1);
        end_of_test();
    end
endmodule

`default_nettype wire
